// ---- dv/fifo_model.sv ----
// far-side receive and transmit fifo stand-in for the uart front end
`default_nettype none
module fifo_model (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 rx_pop,
  input  wire logic                 tx_push,
  input  wire logic                 rx_fifo_reset,
  input  wire logic                 inj,
  input  wire logic                 inj_ovr,
  input  wire logic [10:0]          inj_char,
  output uart_front_pkg::rx_stat_t  rx_stat,
  output logic      [7:0]           rx_data,
  output uart_front_pkg::tx_stat_t  tx_stat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] q[$];
  logic [7:0]  last;
  logic        fe;
  int          tk;
  int          tx;
  ////////////////////////////////////////////////////////////
  // state moves on the edge, outputs launched just after it
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.delete();
      tk = 0;
      tx = 0;
      last = 8'h00;
    end else begin
      tk = (tk + 1) % 4;
      if (rx_fifo_reset)
        q.delete();
      else if (rx_pop && q.size() > 0) begin
        last = q[0][7:0];
        void'(q.pop_front());
      end
      if (inj)
        q.push_back(inj_char);
      // slow drain: holding empties half way, shifter at the end
      if (tx_push)
        tx = 24;
      else if (tx > 0)
        tx--;
    end
    fe = 1'b0;
    foreach (q[i]) fe |= |q[i][10:8];
    rx_stat.level <= 8'(q.size());
    rx_stat.push <= rst_n & inj;
    rx_stat.overrun <= rst_n & inj_ovr;
    rx_stat.head_err <= (q.size() > 0) ? q[0][10:8] : 3'h0;
    rx_stat.fifo_err <= fe;
    rx_stat.bit_tick <= (tk == 0);
    // an empty holding place shows a changed pattern, not stale data
    rx_data <= (q.size() > 0) ? q[0][7:0] : ~last;
    tx_stat.hold_empty <= (tx < 13);
    tx_stat.shift_empty <= (tx == 0);
  end
endmodule
`default_nettype wire

// ---- dv/uart_register_interrupt_front_tb.sv ----
// self-checking bench for the uart register and interrupt front end
`default_nettype none
module uart_register_interrupt_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk, rst_n, reg_wr, reg_rd, rx_pop, tx_push, rx_fifo_reset, irq;
  logic                     inj, inj_ovr, rd_seen;
  logic [2:0]               reg_addr;
  logic [7:0]               reg_wdata, reg_rdata, rx_data, tx_data, d, c;
  logic [3:0]               modem_in_n;
  logic [10:0]              inj_char;
  logic [15:0]              note;
  logic [15:0]              notes[$];
  uart_front_pkg::rx_stat_t rx_stat;
  uart_front_pkg::tx_stat_t tx_stat;
  uart_front_pkg::ctrl_t    ctrl;
  int                       num_errors, check_count;
  ////////////////////////////////////////////////////////////
  uart_register_interrupt_front uart_register_interrupt_front_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_stat(rx_stat), .rx_data(rx_data),
    .tx_stat(tx_stat), .trigger_scale(2'h0), .modem_in_n(modem_in_n), .ctrl(ctrl),
    .rx_pop(rx_pop), .tx_push(tx_push), .tx_data(tx_data), .rx_fifo_reset(rx_fifo_reset),
    .tx_fifo_reset(), .irq(irq));
  fifo_model fifo_model_inst (
    .clk(clk), .rst_n(rst_n), .rx_pop(rx_pop), .tx_push(tx_push), .rx_fifo_reset(rx_fifo_reset),
    .inj(inj), .inj_ovr(inj_ovr), .inj_char(inj_char), .rx_stat(rx_stat), .rx_data(rx_data),
    .tx_stat(tx_stat));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one idle cycle between strobes so no signal is set twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    notes.push_back({m, e & m});
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  task automatic send(input logic p, input logic o, input logic [10:0] ch);
    @(negedge clk);
    inj = p;
    inj_ovr = o;
    inj_char = ch;
    @(negedge clk);
    inj = 1'b0;
    inj_ovr = 1'b0;
  endtask
  task automatic wait_irq(input logic e, input int lim);
    int n;
    n = 0;
    while (irq !== e && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("irq", {15'h0, irq}, {15'h0, e});
  endtask
  // irq answers one cycle after its cause, three is ample
  task automatic quiet;
    repeat (3) @(negedge clk);
    check("irq", {15'h0, irq}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk) begin
    if (rd_seen === 1'b1) begin
      note = notes.pop_front();
      check("reg_rdata", {8'h00, reg_rdata & note[15:8]}, {8'h00, note[7:0]});
    end
  end
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    $display("timeout");
    end_sim();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, inj, inj_ovr} = 5'h00;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    inj_char = 11'h000;
    modem_in_n = 4'hf;
    void'($urandom(32'h5be61b91));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd(3'h1, 8'h00, 8'hff);
    rd(3'h2, 8'h01, 8'hff);
    rd(3'h3, 8'h00, 8'hff);
    rd(3'h5, 8'h60, 8'hff);
    quiet();
    $display("test reset done");
    d = $urandom;
    wr(3'h7, d);
    rd(3'h7, d, 8'hff);
    wr(3'h3, 8'h80);
    wr(3'h0, d);
    wr(3'h1, ~d);
    rd(3'h0, d, 8'hff);
    rd(3'h1, ~d, 8'hff);
    check("divisor", ctrl.divisor, {~d, d});
    wr(3'h3, 8'h03);
    rd(3'h1, 8'h00, 8'hff);
    $display("test registers done");
    wr(3'h1, 8'hf2);
    wait_irq(1'b1, 8);
    rd(3'h1, 8'h02, 8'hff);
    rd(3'h2, 8'h02, 8'hff);
    wait_irq(1'b0, 8);
    wr(3'h0, d);
    check("tx_data", {7'h00, tx_push, tx_data}, {8'h01, d});
    rd(3'h5, 8'h00, 8'h60);
    wait_irq(1'b1, 40);
    rd(3'h5, 8'h20, 8'h60);
    wr(3'h0, ~d);
    wait_irq(1'b0, 8);
    wr(3'h1, 8'h00);
    repeat (30) @(negedge clk);
    quiet();
    $display("test transmit done");
    c = $urandom;
    wr(3'h1, 8'h01);
    send(1'b1, 1'b0, {3'h0, c});
    wait_irq(1'b1, 8);
    rd(3'h2, 8'h04, 8'hff);
    rd(3'h5, 8'h01, 8'h01);
    rd(3'h0, c, 8'hff);
    wait_irq(1'b0, 8);
    rd(3'h5, 8'h00, 8'h01);
    $display("test holding done");
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h41);
    check("rx_fifo_reset", {15'h0, rx_fifo_reset}, 16'h0001);
    rd(3'h2, 8'hc1, 8'hff);
    send(1'b1, 1'b0, {3'h0, c});
    quiet();
    rd(3'h5, 8'h01, 8'h01);
    wr(3'h1, 8'h01);
    repeat (2) send(1'b1, 1'b0, 11'($urandom & 8'hff));
    quiet();
    send(1'b1, 1'b0, 11'h05a);
    wait_irq(1'b1, 8);
    rd(3'h2, 8'hc4, 8'hff);
    rd(3'h0, c, 8'hff);
    wait_irq(1'b0, 8);
    rd(3'h2, 8'hc1, 8'hff);
    wait_irq(1'b1, 400);
    rd(3'h2, 8'hcc, 8'hff);
    wr(3'h2, 8'h03);
    check("rx_fifo_reset", {15'h0, rx_fifo_reset}, 16'h0001);
    wait_irq(1'b0, 8);
    $display("test fifo done");
    wr(3'h1, 8'h05);
    send(1'b1, 1'b0, {3'h0, c});
    wait_irq(1'b1, 8);
    send(1'b0, 1'b1, 11'h000);
    rd(3'h2, 8'hc6, 8'hff);
    rd(3'h5, 8'h03, 8'h03);
    rd(3'h2, 8'hc4, 8'hff);
    send(1'b1, 1'b0, {3'h1, d});
    rd(3'h0, c, 8'hff);
    rd(3'h2, 8'hc6, 8'hff);
    rd(3'h5, 8'h85, 8'h9d);
    rd(3'h2, 8'hc4, 8'hff);
    rd(3'h0, d, 8'hff);
    rd(3'h5, 8'h00, 8'h9d);
    wait_irq(1'b0, 8);
    $display("test line status done");
    wr(3'h1, 8'h00);
    rd(3'h6, 8'h00, 8'hf0);
    wr(3'h1, 8'h08);
    quiet();
    modem_in_n = 4'he;
    wait_irq(1'b1, 8);
    rd(3'h2, 8'hc0, 8'hff);
    rd(3'h6, 8'h11, 8'hf1);
    wait_irq(1'b0, 8);
    wr(3'h1, 8'h00);
    modem_in_n = 4'hf;
    quiet();
    $display("test modem done");
    end_sim();
  end
endmodule
`default_nettype wire

// ---- src/irq_priority.sv ----
// fixed-priority encoder of the five interrupt sources
`include "uart_front_consts.svh"
`default_nettype none
module irq_priority (
  input  wire logic [4:0] pend,
  output logic      [3:0] code
);
  // pend order: 4 line status, 3 timeout, 2 rx data, 1 tx ready, 0 modem
  always_comb begin
    if (pend[4]) begin
      code = `CODE_LSI;
    end else if (pend[3]) begin
      code = `CODE_TO;
    end else if (pend[2]) begin
      code = `CODE_RDA;
    end else if (pend[1]) begin
      code = `CODE_THR;
    end else if (pend[0]) begin
      code = `CODE_MS;
    end else begin
      code = `CODE_NONE;
    end
  end
endmodule
`default_nettype wire

// ---- src/modem_sync.sv ----
// two-flop synchroniser for the modem input pins
`default_nettype none
module modem_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] pin_n,
  output logic      [3:0] sync_n
);
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } sync_st_t;
  sync_st_t st;
  sync_st_t n;
  // pins idle high, so reset to the inactive level
  always_comb begin
    n    = st;
    n.s1 = pin_n;
    n.s2 = st.s1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{s1: 4'hf, s2: 4'hf};
    end else begin
      st <= n;
    end
  end
  assign sync_n = st.s2;
endmodule
`default_nettype wire

// ---- src/uart_front_consts.svh ----
// offsets, field positions, reset values and counts of the uart register front end
`ifndef UART_FRONT_CONSTS_SVH
`define UART_FRONT_CONSTS_SVH

`define OFS_DATA       3'h0
`define OFS_MASK       3'h1
`define OFS_SRC        3'h2
`define OFS_FMT        3'h3
`define OFS_MODEM      3'h4
`define OFS_LINE       3'h5
`define OFS_MSTAT      3'h6
`define OFS_SCRATCH    3'h7

`define FMT_DIVISOR_BIT 7
`define FMT_STOP_BIT    2
`define FMT_PAR_BIT     3
`define MASK_RDA_BIT    0
`define MASK_THR_BIT    1
`define MASK_LSI_BIT    2
`define MASK_MS_BIT     3
`define FCTL_EN_BIT     0
`define FCTL_RXRST_BIT  1
`define FCTL_TXRST_BIT  2

`define RST_DIV_LOW    8'h01
`define RST_ZERO       8'h00

`define CODE_LSI       4'h6
`define CODE_TO        4'hc
`define CODE_RDA       4'h4
`define CODE_THR       4'h2
`define CODE_MS        4'h0
`define CODE_NONE      4'h1

`define TRIG_0         8'h01
`define TRIG_1         8'h04
`define TRIG_2         8'h08
`define TRIG_3         8'h0e

`define TO_CHARS       7'h04
`define TO_EXTRA_BITS  7'h0c
`define START_BITS     7'h01
`define MIN_WORD_BITS  7'h05

`endif

// ---- src/uart_front_pkg.sv ----
// types shared by the uart register front end
`default_nettype none
package uart_front_pkg;
  typedef struct packed {
    logic [7:0] level;
    logic       push;
    logic       overrun;
    logic [2:0] head_err;
    logic       fifo_err;
    logic       bit_tick;
  } rx_stat_t;
  typedef struct packed {
    logic hold_empty;
    logic shift_empty;
  } tx_stat_t;
  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0]  line_format;
    logic [4:0]  modem_ctrl;
    logic        fifo_en;
    logic [7:0]  rx_trigger;
  } ctrl_t;
endpackage
`default_nettype wire

// ---- src/uart_register_interrupt_front.sv ----
// register decode, interrupt masking and priority, line and modem status of one uart channel
//
// Overview of operation
// - eight offsets decode the channel's registers
// - divisor bit swaps offsets 0,1 to divisor
// - four mask bits, upper four read zero
// - fifo rx interrupt follows trigger level crossing
// - source code and line clear together
// - data ready set on arrival, clear empty
// - non-fifo rx interrupt while holding has data
// - all masks clear gives polled mode
// - overrun flagged, interrupts immediately when enabled
// - parity, framing, break describe holding character
// - bit 5 shows transmit holding empty
// - bit 6 shows holding and shifter empty
// - bit 7 shows any error in fifo, in fifo mode only
// - tx ready on empty, or enabling while empty
// - modem interrupts only with mask bit 3
// - status read returns highest pending source
// - status upper bits show fifo enable
// - six fixed source codes by priority
// - tx ready clears on a status read that reports it, or a holding write
// - timeout after four chars plus twelve bits
`include "uart_front_consts.svh"
`default_nettype none
module uart_register_interrupt_front (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [2:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  input  wire uart_front_pkg::rx_stat_t  rx_stat,
  input  wire logic [7:0]                rx_data,
  input  wire uart_front_pkg::tx_stat_t  tx_stat,
  input  wire logic [1:0]                trigger_scale,
  input  wire logic [3:0]                modem_in_n,
  output uart_front_pkg::ctrl_t          ctrl,
  output logic                           rx_pop,
  output logic                           tx_push,
  output logic      [7:0]                tx_data,
  output logic                           rx_fifo_reset,
  output logic                           tx_fifo_reset,
  output logic                           irq
);
  typedef struct packed {
    uart_front_pkg::ctrl_t ctl;
    logic [3:0] interrupt_mask;
    logic [7:0] scratch_pad;
    logic [1:0] trig_sel;
    logic       ovr;
    logic       lsr_ack;
    logic       thre;
    logic       tx_empty_d;
    logic       to_pend;
    logic [6:0] to_cnt;
    logic [3:0] delta;
    logic [3:0] modem_d;
    logic [7:0] rdata;
    logic       rx_pop;
    logic       tx_push;
    logic [7:0] tx_data;
    logic       rx_rst;
    logic       tx_rst;
    logic       irq;
  } front_st_t;

  front_st_t  st;
  front_st_t  n;
  logic [3:0] modem_s;
  logic [4:0] pend;
  logic [3:0] code;
  logic       dlab;
  logic       rd_data;
  logic       wr_data;
  logic       rd_src;
  logic       rd_line;
  logic       rd_mstat;
  logic       wr_mask;
  logic       thr_clr;
  logic [7:0] line_condition_status;
  logic [6:0] char_bits;
  logic [6:0] to_limit;
  logic [7:0] trig_base;

  modem_sync u_sync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pin_n  (modem_in_n),
    .sync_n (modem_s)
  );

  irq_priority u_prio (
    .pend (pend),
    .code (code)
  );

  ////////////////////////////////////////////////////////////////////////
  // enabled pending sources of a given state
  function automatic logic [4:0] pend_f(input front_st_t s, input uart_front_pkg::rx_stat_t r);
    logic have;
    logic rda;
    logic lsi;
    have = r.level != 8'h00;
    rda  = s.ctl.fifo_en ? (r.level >= s.ctl.rx_trigger) : have;
    lsi  = s.ovr | ((|r.head_err) & ~s.lsr_ack);
    pend_f = {s.interrupt_mask[`MASK_LSI_BIT] & lsi,
              s.interrupt_mask[`MASK_RDA_BIT] & s.to_pend,
              s.interrupt_mask[`MASK_RDA_BIT] & rda,
              s.interrupt_mask[`MASK_THR_BIT] & s.thre,
              s.interrupt_mask[`MASK_MS_BIT] & (|s.delta)};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n          = st;
    n.rx_pop   = 1'b0;
    n.tx_push  = 1'b0;
    n.rx_rst   = 1'b0;
    n.tx_rst   = 1'b0;
    dlab       = st.ctl.line_format[`FMT_DIVISOR_BIT];
    rd_data    = reg_rd && reg_addr == `OFS_DATA && !dlab;
    wr_data    = reg_wr && reg_addr == `OFS_DATA && !dlab;
    rd_src     = reg_rd && reg_addr == `OFS_SRC;
    rd_line    = reg_rd && reg_addr == `OFS_LINE;
    rd_mstat   = reg_rd && reg_addr == `OFS_MSTAT;
    wr_mask    = reg_wr && reg_addr == `OFS_MASK && !dlab;
    pend       = pend_f(st, rx_stat);
    line_condition_status        = {st.ctl.fifo_en & rx_stat.fifo_err,
                  tx_stat.hold_empty & tx_stat.shift_empty,
                  tx_stat.hold_empty,
                  rx_stat.head_err,
                  st.ovr,
                  rx_stat.level != 8'h00};

    // modem deltas: a change in the clearing read cycle still lands
    n.modem_d  = modem_s;
    n.delta    = (rd_mstat ? 4'h0 : st.delta) | (modem_s ^ st.modem_d);

    // overrun sticky until line status read, set wins
    n.ovr      = rx_stat.overrun | (st.ovr & ~rd_line);
    // error bits of the held character interrupt once per character
    if (rd_line) begin
      n.lsr_ack = 1'b1;
    end
    if (rx_stat.push || rd_data) begin
      n.lsr_ack = 1'b0;
    end

    // transmit ready: edge of empty, or enabling while already empty
    // only a status read that reports it, or a holding write, consumes it, so a lower
    // priority read never silently drops a pending transmit ready
    thr_clr      = (rd_src && code == `CODE_THR) || wr_data;
    n.tx_empty_d = tx_stat.hold_empty;
    n.thre       = (st.thre & ~thr_clr)
                 | (tx_stat.hold_empty & ~st.tx_empty_d)
                 | (wr_mask & reg_wdata[`MASK_THR_BIT] & ~st.interrupt_mask[`MASK_THR_BIT]
                    & tx_stat.hold_empty);

    // receive timeout in bit ticks; 1.5 stop bits counted as two
    // the count parks one below to_limit, so it cannot wrap and fire twice
    char_bits = `START_BITS + `MIN_WORD_BITS + {5'h00, st.ctl.line_format[1:0]}
              + {6'h00, st.ctl.line_format[`FMT_PAR_BIT]}
              + (st.ctl.line_format[`FMT_STOP_BIT] ? 7'h02 : 7'h01);
    to_limit  = 7'(char_bits * `TO_CHARS) + `TO_EXTRA_BITS;
    if (!st.ctl.fifo_en || rx_stat.level == 8'h00 || rd_data) begin
      n.to_cnt  = 7'h00;
      n.to_pend = 1'b0;
    end else if (rx_stat.push) begin
      n.to_cnt  = 7'h00;
    end else if (rx_stat.bit_tick && !st.to_pend) begin
      if (st.to_cnt == to_limit - 7'h01) begin
        n.to_pend = 1'b1;
      end else begin
        n.to_cnt  = st.to_cnt + 7'h01;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_DATA: begin
          if (dlab) begin
            n.ctl.divisor[7:0] = reg_wdata;
          end else begin
            n.tx_push = 1'b1;
            n.tx_data = reg_wdata;
          end
        end
        `OFS_MASK: begin
          if (dlab) begin
            n.ctl.divisor[15:8] = reg_wdata;
          end else begin
            n.interrupt_mask = reg_wdata[3:0];
          end
        end
        `OFS_SRC: begin
          // a change of fifo mode flushes both fifos
          n.ctl.fifo_en = reg_wdata[`FCTL_EN_BIT];
          n.rx_rst      = reg_wdata[`FCTL_EN_BIT] != st.ctl.fifo_en;
          n.tx_rst      = reg_wdata[`FCTL_EN_BIT] != st.ctl.fifo_en;
          if (reg_wdata[`FCTL_EN_BIT]) begin
            n.rx_rst   = n.rx_rst | reg_wdata[`FCTL_RXRST_BIT];
            n.tx_rst   = n.tx_rst | reg_wdata[`FCTL_TXRST_BIT];
            n.trig_sel = reg_wdata[7:6];
          end
        end
        `OFS_FMT:     n.ctl.line_format = reg_wdata;
        `OFS_MODEM:   n.ctl.modem_ctrl  = reg_wdata[4:0];
        `OFS_SCRATCH: n.scratch_pad             = reg_wdata;
        default: begin
        end
      endcase
    end

    unique case (n.trig_sel)
      2'h0: trig_base = `TRIG_0;
      2'h1: trig_base = `TRIG_1;
      2'h2: trig_base = `TRIG_2;
      2'h3: trig_base = `TRIG_3;
    endcase
    // larger fifo depths scale the whole trigger table by a power of two
    n.ctl.rx_trigger = trig_base << trigger_scale;

    ////////////////////////////////////////////////////////////////////////
    // register reads, data valid the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_DATA: begin
          n.rdata  = dlab ? st.ctl.divisor[7:0] : rx_data;
          n.rx_pop = !dlab;
        end
        `OFS_MASK:    n.rdata = dlab ? st.ctl.divisor[15:8] : {4'h0, st.interrupt_mask};
        `OFS_SRC:     n.rdata = {{2{st.ctl.fifo_en}}, 2'h0, code};
        `OFS_FMT:     n.rdata = st.ctl.line_format;
        `OFS_MODEM:   n.rdata = {3'h0, st.ctl.modem_ctrl};
        `OFS_LINE:    n.rdata = line_condition_status;
        `OFS_MSTAT:   n.rdata = {~modem_s, st.delta};
        `OFS_SCRATCH: n.rdata = st.scratch_pad;
        default: begin
        end
      endcase
    end

    // line drops in the same cycle the last source clears
    n.irq = |pend_f(n, rx_stat);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st                 <= '0;
      st.ctl.divisor     <= {`RST_ZERO, `RST_DIV_LOW};
      st.ctl.rx_trigger  <= `TRIG_0;
      st.tx_empty_d      <= 1'b1;
      st.modem_d         <= 4'hf;
    end else begin
      st <= n;
    end
  end

  assign reg_rdata     = st.rdata;
  assign ctrl          = st.ctl;
  assign rx_pop        = st.rx_pop;
  assign tx_push       = st.tx_push;
  assign tx_data       = st.tx_data;
  assign rx_fifo_reset = st.rx_rst;
  assign tx_fifo_reset = st.tx_rst;
  assign irq           = st.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_data_read_pop: assert property (rd_data |=> rx_pop && reg_rdata == $past(rx_data))
    else $error("holding read did not pop");
  a_div_low_write: assert property (reg_wr && reg_addr == `OFS_DATA && dlab
    |=> ctrl.divisor[7:0] == $past(reg_wdata) && !tx_push)
    else $error("divisor write leaked to transmit");
  a_mask_upper_zero: assert property (reg_rd && reg_addr == `OFS_MASK && !dlab |=> reg_rdata[7:4] == 4'h0)
    else $error("mask upper bits not zero");
  a_rda_code: assert property (pend == 5'b00100 |-> code == `CODE_RDA)
    else $error("rx data code wrong");
  a_ready_bit: assert property (rd_line |=> reg_rdata[0] == ($past(rx_stat.level) != 8'h00))
    else $error("data ready bit wrong");
  a_polled_quiet: assert property (st.interrupt_mask == 4'h0 |-> !irq && code == `CODE_NONE)
    else $error("interrupt in polled mode");
  a_overrun_irq: assert property (rx_stat.overrun && st.interrupt_mask[`MASK_LSI_BIT] && n.interrupt_mask[`MASK_LSI_BIT]
    |=> irq && code == `CODE_LSI)
    else $error("overrun did not interrupt");
  a_empty_both: assert property (rd_line |=> reg_rdata[6] == $past(tx_stat.hold_empty && tx_stat.shift_empty))
    else $error("shifter empty bit wrong");
  a_thre_enable: assert property (wr_mask && reg_wdata[`MASK_THR_BIT] && !st.interrupt_mask[`MASK_THR_BIT]
    && tx_stat.hold_empty |=> irq)
    else $error("enable while empty gave no interrupt");
  a_fifo_bits: assert property (rd_src |=> reg_rdata[7:4] == {{2{$past(st.ctl.fifo_en)}}, 2'h0})
    else $error("status upper bits wrong");
  a_thr_clear: assert property (wr_data |=> !st.thre || $past(tx_stat.hold_empty && !st.tx_empty_d))
    else $error("transmit ready not cleared");
  a_timeout_count: assert property ($rose(st.to_pend) |-> $past(st.to_cnt) == $past(to_limit) - 7'h01)
    else $error("timeout at wrong count");

  ////////////////////////////////////////////////////////////////////////
  // register side effects and status bits
  a_tx_push_data: assert property (wr_data |=> tx_push && tx_data == $past(reg_wdata))
    else $error("holding write did not push");
  a_fifo_flush: assert property (reg_wr && reg_addr == `OFS_SRC && reg_wdata[`FCTL_EN_BIT]
    && reg_wdata[`FCTL_RXRST_BIT] |=> rx_fifo_reset)
    else $error("rx fifo reset not pulsed");
  a_scratch_write: assert property (reg_wr && reg_addr == `OFS_SCRATCH |=> st.scratch_pad == $past(reg_wdata))
    else $error("scratch write lost");
  a_src_read_code: assert property (rd_src |=> reg_rdata[3:0] == $past(code))
    else $error("status read code wrong");
  a_overrun_sticky: assert property (rx_stat.overrun |=> st.ovr)
    else $error("overrun not held");
  a_modem_delta: assert property (modem_s != st.modem_d |=> st.delta != 4'h0)
    else $error("modem change not recorded");
  a_thr_empty_bit: assert property (rd_line |=> reg_rdata[5] == $past(tx_stat.hold_empty))
    else $error("holding empty bit wrong");
  a_global_error: assert property (rd_line
    |=> reg_rdata[7] == $past(st.ctl.fifo_en && rx_stat.fifo_err))
    else $error("fifo error bit wrong");

  // one cover per source that the bench is meant to reach
  c_lsi_irq:   cover property (irq && code == `CODE_LSI);
  c_modem_irq: cover property (irq && code == `CODE_MS);
  c_rda_irq:   cover property (irq && code == `CODE_RDA);
  c_timeout:   cover property (irq && code == `CODE_TO);
  c_thre_read: cover property (irq && code == `CODE_THR ##1 rd_src);
endmodule
`default_nettype wire
